/* File: design/bfh_lscount.sv */
// Low-side current-limit event counter with consecutive clean-cycle clear.
`timescale 1ns/100ps
module bfh_lscount
  import bfh_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic sample_i,
  input  wire logic over_i,
  input  wire logic clear_i,
  output logic      trip_o
);
  logic [CNT_W-1:0] events;
  logic [CNT_W-1:0] clean;
  logic [CNT_W-1:0] next_events;
  logic [CNT_W-1:0] next_clean;

  always_comb begin
    next_events = events;
    next_clean  = clean;
    if (clear_i) begin
      next_events = '0;
      next_clean  = '0;
    end else if (sample_i) begin
      if (over_i) begin
        next_clean = '0;
        if (events < CNT_W'(LS_TRIP_EVENTS)) begin
          next_events = events + CNT_W'(1);
        end
      end else if (clean == CNT_W'(LS_CLEAR_CYCLES - 1)) begin
        next_clean  = '0;
        next_events = '0;
      end else begin
        next_clean = clean + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      events <= '0;
      clean  <= '0;
    end else begin
      events <= next_events;
      clean  <= next_clean;
    end
  end

  assign trip_o = (events == CNT_W'(LS_TRIP_EVENTS));
endmodule

/* File: design/bfh_pkg.sv */
// Package of constants and types for the buck fault hiccup sequencer.
package bfh_pkg;

  localparam int unsigned CLK_MHZ           = 250;
  localparam int unsigned HS_BLANK_NS       = 200;
  localparam int unsigned HS_BLANK_CYC      = (HS_BLANK_NS * CLK_MHZ) / 1000;
  localparam int unsigned LS_SAMPLE_NS      = 50;
  localparam int unsigned LS_SAMPLE_CYC     = (LS_SAMPLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned UV_FILTER_NS      = 7000;
  localparam int unsigned UV_FILTER_CYC     = (UV_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned COOLDOWN_US10     = 55000;
  localparam int unsigned COOLDOWN_CYC      = (COOLDOWN_US10 * CLK_MHZ) / 10;
  localparam int unsigned SOFTSTART_US10    = 36000;
  localparam int unsigned SOFTSTART_CYC     = (SOFTSTART_US10 * CLK_MHZ) / 10;
  localparam int unsigned LS_TRIP_EVENTS    = 15;
  localparam int unsigned LS_CLEAR_CYCLES   = 32;

  localparam int unsigned REF_W             = 10;
  localparam int unsigned TMR_W             = 21;
  localparam int unsigned SHORT_W           = 11;
  localparam int unsigned CNT_W             = 6;

  localparam logic [REF_W-1:0] REF_ZERO     = 10'h000;
  localparam logic [REF_W-1:0] REF_FULL     = 10'h3FF;

  typedef enum logic [1:0] {
    BFH_RUN      = 2'b00,
    BFH_COOLDOWN = 2'b01,
    BFH_SOFTST   = 2'b10
  } bfh_state_t;

  // Lowest of three reference codes.
  function automatic logic [REF_W-1:0] bfh_min3(input logic [REF_W-1:0] a,
                                                input logic [REF_W-1:0] b,
                                                input logic [REF_W-1:0] c);
    logic [REF_W-1:0] m;
    m = (a < b) ? a : b;
    return (m < c) ? m : c;
  endfunction

endpackage

/* File: design/bfh_sequencer.sv */
// Top of the buck fault hiccup sequencer: fault qualification, hiccup timing and reference.
// Operation
// - Ignore high-side overcurrent for 200 ns after every high-side turn-on.
// - Unblanked high-side overcurrent enters hiccup immediately, no cycle counting.
// - Under-voltage detector stays disarmed until soft-start ramp has ended.
// - Armed under-voltage must persist over 7 us before hiccup is entered.
// - Hiccup turns off both gate drives and starts a 5.5 ms cool-down.
// - After cool-down, run an internal soft-start ramp of 3.6 ms.
// - Fifteen over-limit low-side samples enter hiccup.
// - Low-side limit sampled once per switching cycle, early in the off time.
// - Thirty-two consecutive clean samples clear the low-side event counter.
// - Error-amplifier reference is the lowest of bandgap, external and internal ramps.
// - Hiccup leaves the external ramp alone; only lockout or shutdown resets it.
// - Hiccup entry loads cool-down timer and returns internal ramp to zero.
// - During any soft-start both current-limit detectors stay armed.
// - In low-side limit mode skip high-side pulse until valley reaches threshold.
// - Shutdown or lockout disables both gate drives and resets the external ramp.
// - Low-side current sample is taken 50 ns after low-side turn-on.
`timescale 1ns/100ps
module bfh_sequencer
  import bfh_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             shutdown_i,
  input  wire logic             supply_lockout_i,
  input  wire logic             pwm_hs_req_i,
  input  wire logic             cycle_start_i,
  input  wire logic             hs_ocp_cmp_i,
  input  wire logic             ls_ocp_cmp_i,
  input  wire logic             output_undervoltage_fault_i,
  input  wire logic [REF_W-1:0] bandgap_ref_i,
  input  wire logic [REF_W-1:0] ext_ss_ref_i,
  output logic                  hs_gate_o,
  output logic                  ls_gate_o,
  output logic                  ext_ss_discharge_o,
  output logic [REF_W-1:0]      ea_ref_o,
  output logic                  hiccup_o,
  output logic                  soft_start_o
);

  // All external levels are asynchronous to clk_i.
  logic shdn_s;
  logic supply_lockout_s;
  logic pwm_s;
  logic cyc_s;
  logic hs_cmp_s;
  logic ls_cmp_s;
  logic uv_s;

  // Every single-bit pin reaches the logic two cycles after it changes; the reference buses are not synchronised.
  bfh_sync u_sync_shdn (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (shutdown_i),
    .q_o     (shdn_s)
  );

  bfh_sync u_sync_supply_lockout (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (supply_lockout_i),
    .q_o     (supply_lockout_s)
  );

  bfh_sync u_sync_pwm (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (pwm_hs_req_i),
    .q_o     (pwm_s)
  );

  bfh_sync u_sync_cyc (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (cycle_start_i),
    .q_o     (cyc_s)
  );

  bfh_sync u_sync_hs (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (hs_ocp_cmp_i),
    .q_o     (hs_cmp_s)
  );

  bfh_sync u_sync_ls (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (ls_ocp_cmp_i),
    .q_o     (ls_cmp_s)
  );

  bfh_sync u_sync_uv (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (output_undervoltage_fault_i),
    .q_o     (uv_s)
  );

  logic off_all;
  assign off_all = shdn_s | supply_lockout_s;

  // Sequencer state and timers.
  bfh_state_t       state;
  bfh_state_t       next_state;
  logic [TMR_W-1:0] tmr;
  logic [TMR_W-1:0] next_tmr;
  logic [REF_W-1:0] int_ref;
  logic [REF_W-1:0] next_int_ref;
  logic             uv_armed;
  logic             next_uv_armed;

  // Switching-cycle gate timing.
  logic             hs_on;
  logic             next_hs_on;
  logic             ls_on;
  logic             next_ls_on;
  logic             cl_mode;
  logic             next_cl_mode;
  logic             cyc_d;
  logic             next_cyc_d;
  logic [SHORT_W-1:0] hs_blank;
  logic [SHORT_W-1:0] next_hs_blank;
  logic [SHORT_W-1:0] ls_dly;
  logic [SHORT_W-1:0] next_ls_dly;
  logic             ls_armed;
  logic             next_ls_armed;
  logic [SHORT_W-1:0] uv_cnt;
  logic [SHORT_W-1:0] next_uv_cnt;

  logic ls_sample;
  logic ls_trip;
  logic hs_trip;
  logic uv_trip;
  logic fault;
  logic cyc_rise;

  assign cyc_rise  = cyc_s & ~cyc_d;
  // Sample only once the low-side switch has settled past its turn-on ringing.
  assign ls_sample = ls_armed && ls_dly == SHORT_W'(LS_SAMPLE_CYC);
  assign hs_trip   = hs_on && hs_blank == '0 && hs_cmp_s;
  assign uv_trip   = uv_cnt == SHORT_W'(UV_FILTER_CYC);
  // Both current detectors remain live through soft-start; only the UV check waits.
  assign fault     = state != BFH_COOLDOWN && (hs_trip || ls_trip || uv_trip);

  bfh_lscount u_lscount (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .sample_i (ls_sample),
    .over_i   (ls_cmp_s),
    .clear_i  (fault || off_all),
    .trip_o   (ls_trip)
  );

  // Hiccup state machine.
  always_comb begin
    next_state    = state;
    next_tmr      = tmr;
    next_int_ref  = int_ref;
    next_uv_armed = uv_armed;
    if (off_all) begin
      next_state    = BFH_RUN;
      next_tmr      = '0;
      next_int_ref  = REF_FULL;
      next_uv_armed = 1'b0;
    end else if (fault) begin
      next_state    = BFH_COOLDOWN;
      next_tmr      = TMR_W'(COOLDOWN_CYC - 1);
      next_int_ref  = REF_ZERO;
      next_uv_armed = 1'b0;
    end else begin
      case (state)
        BFH_RUN: begin
          // Arm UV once the external ramp has passed the bandgap.
          if (ext_ss_ref_i >= bandgap_ref_i) begin
            next_uv_armed = 1'b1;
          end
        end
        BFH_COOLDOWN: begin
          if (tmr == '0) begin
            next_state = BFH_SOFTST;
            next_tmr   = TMR_W'(SOFTSTART_CYC - 1);
          end else begin
            next_tmr = tmr - TMR_W'(1);
          end
        end
        BFH_SOFTST: begin
          next_int_ref = REF_W'(((SOFTSTART_CYC - 1 - tmr) * 1023) / (SOFTSTART_CYC - 1));
          if (tmr == '0) begin
            next_state    = BFH_RUN;
            next_int_ref  = REF_FULL;
            next_uv_armed = 1'b1;
          end else begin
            next_tmr = tmr - TMR_W'(1);
          end
        end
        default: next_state = BFH_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state    <= BFH_RUN;
      tmr      <= '0;
      int_ref  <= REF_FULL;
      uv_armed <= 1'b0;
    end else begin
      state    <= next_state;
      tmr      <= next_tmr;
      int_ref  <= next_int_ref;
      uv_armed <= next_uv_armed;
    end
  end

  // Gate drive and detector timing.
  always_comb begin
    next_cyc_d    = cyc_s;
    next_cl_mode  = cl_mode;
    next_hs_on    = hs_on;
    next_ls_on    = ls_on;
    next_hs_blank = (hs_blank != '0) ? hs_blank - SHORT_W'(1) : hs_blank;
    next_ls_dly   = ls_dly;
    next_ls_armed = ls_armed;
    next_uv_cnt   = '0;
    if (uv_armed && uv_s && !uv_trip) begin
      next_uv_cnt = uv_cnt + SHORT_W'(1);
    end
    if (ls_sample) begin
      next_ls_armed = 1'b0;
      next_cl_mode  = ls_cmp_s;
    end else if (ls_armed) begin
      next_ls_dly = ls_dly + SHORT_W'(1);
    end
    if (off_all || fault || state == BFH_COOLDOWN) begin
      next_hs_on    = 1'b0;
      next_ls_on    = 1'b0;
      next_ls_armed = 1'b0;
      next_uv_cnt   = '0;
    end else begin
      // Skip the on-pulse in limit mode; turn on once the valley reaches the threshold.
      // A new cycle is skipped while a valley sample is pending, so every off time is sampled once
      // and the current sensing keeps its minimum off time.
      if ((cyc_rise && !cl_mode && !ls_armed) ||
          (cl_mode && ls_on && !ls_cmp_s && !ls_sample)) begin
        next_hs_on    = 1'b1;
        next_cl_mode  = 1'b0;
        next_hs_blank = SHORT_W'(HS_BLANK_CYC);
        next_ls_on    = 1'b0;
        next_ls_armed = 1'b0;
      end else if (hs_on && (!pwm_s || cyc_rise)) begin
        next_hs_on    = 1'b0;
        next_ls_on    = 1'b1;
        next_ls_armed = 1'b1;
        next_ls_dly   = '0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_d    <= 1'b0;
      cl_mode  <= 1'b0;
      hs_on    <= 1'b0;
      ls_on    <= 1'b0;
      hs_blank <= '0;
      ls_dly   <= '0;
      ls_armed <= 1'b0;
      uv_cnt   <= '0;
    end else begin
      cyc_d    <= next_cyc_d;
      cl_mode  <= next_cl_mode;
      hs_on    <= next_hs_on;
      ls_on    <= next_ls_on;
      hs_blank <= next_hs_blank;
      ls_dly   <= next_ls_dly;
      ls_armed <= next_ls_armed;
      uv_cnt   <= next_uv_cnt;
    end
  end

  // Outputs; the reference is registered to keep the DAC code glitch free.
  logic [REF_W-1:0] next_ea_ref;
  assign next_ea_ref = bfh_min3(bandgap_ref_i, ext_ss_ref_i, int_ref);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ea_ref_o <= REF_ZERO;
    end else begin
      ea_ref_o <= next_ea_ref;
    end
  end

  assign hs_gate_o          = hs_on;
  assign ls_gate_o          = ls_on;
  assign ext_ss_discharge_o = off_all;
  assign hiccup_o           = state == BFH_COOLDOWN;
  assign soft_start_o       = state == BFH_SOFTST;

endmodule

/* File: design/bfh_sync.sv */
// Two-flop synchroniser for asynchronous comparator and pin inputs.
`timescale 1ns/100ps
module bfh_sync
  import bfh_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta;
  logic next_meta;
  logic next_q;

  always_comb begin
    next_meta = d_i;
    next_q    = meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      q_o  <= 1'b0;
    end else begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end
endmodule

/* File: tb/bfh_power_stage.sv */
// Behavioural switching stage and fault comparators facing the sequencer.
`timescale 1ns/100ps
module bfh_power_stage (
  input  wire logic clk_i,
  input  wire logic hs_gate_i,
  input  wire logic ls_gate_i,
  input  wire logic run_i,
  input  wire logic ls_over_i,
  input  int        hs_at_i,
  output logic      cycle_start_o = 1'b0,
  output logic      pwm_hs_req_o = 1'b0,
  output logic      hs_ocp_cmp_o = 1'b0,
  output logic      ls_ocp_cmp_o = 1'b0
);
  int ph = 0;
  int hs_t = 0;
  int ls_t = 0;
  // A 200 clock period keeps each high-side pulse far longer than the blanking time.
  always @(posedge clk_i) begin
    ph            <= run_i ? (ph + 1) % 200 : 0;
    hs_t          <= hs_gate_i ? hs_t + 1 : 0;
    ls_t          <= ls_gate_i ? ls_t + 1 : 0;
    cycle_start_o <= run_i && ph < 100;
    pwm_hs_req_o  <= run_i && ph < 120;
    hs_ocp_cmp_o  <= hs_at_i > 0 && hs_gate_i && hs_t >= hs_at_i && hs_t < hs_at_i + 10;
    ls_ocp_cmp_o  <= ls_over_i && ls_gate_i && ls_t < 20;
  end
endmodule

/* File: tb/bfh_sequencer_assertions.sv */
// Port checker for the buck fault hiccup sequencer.
`timescale 1ns/100ps
module bfh_sequencer_assertions
  import bfh_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             rst_n_i,
  input wire logic             shutdown_i,
  input wire logic             supply_lockout_i,
  input wire logic             hs_ocp_cmp_i,
  input wire logic [REF_W-1:0] bandgap_ref_i,
  input wire logic [REF_W-1:0] ext_ss_ref_i,
  input wire logic             hs_gate_o,
  input wire logic             ls_gate_o,
  input wire logic             ext_ss_discharge_o,
  input wire logic [REF_W-1:0] ea_ref_o,
  input wire logic             hiccup_o,
  input wire logic             soft_start_o
);
  int hs_on;
  int hic_n;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_on <= 0;
      hic_n <= 0;
    end else begin
      hs_on <= hs_gate_o ? hs_on + 1 : 0;
      hic_n <= hiccup_o ? hic_n + 1 : 0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_HIC_GATES: assert property (hiccup_o && $past(hiccup_o) |-> !hs_gate_o && !ls_gate_o)
    else $error("gate driven during hiccup");
  AST_HIC_HOLD: assert property ($rose(hiccup_o) |=> hiccup_o [*8])
    else $error("hiccup dropped early");
  AST_HIC_EXT: assert property ($rose(hiccup_o) |-> !ext_ss_discharge_o)
    else $error("external ramp discharged by hiccup");
  AST_HIC_REF: assert property (hiccup_o && $past(hiccup_o, 2) |-> ea_ref_o == REF_ZERO)
    else $error("internal ramp not at zero in hiccup");
  AST_SD_DIS: assert property ((shutdown_i || supply_lockout_i) [*4] |-> ext_ss_discharge_o)
    else $error("external ramp not discharged");
  AST_SD_GATES: assert property ((shutdown_i || supply_lockout_i) [*5] |-> !hs_gate_o && !ls_gate_o)
    else $error("gate on in shutdown");
  AST_REF_MIN: assert property (bandgap_ref_i == $past(bandgap_ref_i, 2) &&
    ext_ss_ref_i == $past(ext_ss_ref_i, 2) |-> ea_ref_o <= bandgap_ref_i && ea_ref_o <= ext_ss_ref_i)
    else $error("reference above a source");
  AST_HS_TRIP: assert property ((hs_on > 55 && hs_ocp_cmp_i && hs_gate_o) [*3] |-> ##[0:2] hiccup_o)
    else $error("high-side trip missed");
  AST_COOL_SOFT: assert property ($fell(hiccup_o) && !ext_ss_discharge_o |->
    soft_start_o && hic_n >= COOLDOWN_CYC - 1)
    else $error("cool-down end wrong");
endmodule
bind bfh_sequencer bfh_sequencer_assertions u_chk (.*);

/* File: tb/bfh_sequencer_bench.sv */
// Self-checking bench for the buck fault hiccup sequencer.
`timescale 1ns/100ps
module bfh_sequencer_bench;
  import bfh_pkg::*;
  logic             clk_i = 1'b0;
  logic             rst_n_i = 1'b0;
  logic             sd = 1'b0;
  logic             lock = 1'b0;
  logic             uv = 1'b0;
  logic             run = 1'b0;
  logic             ls_over = 1'b0;
  logic [REF_W-1:0] bg = 10'h1F4;
  logic [REF_W-1:0] ext = 10'h3FF;
  logic [REF_W-1:0] ref_o;
  logic             pwm, cs, hs_cmp, ls_cmp, hs_g, ls_g, dis, hic, ss;
  int               hs_at = 0;
  int               err_total = 0;
  int               n_tests = 0;
  int               n, a, b, cnt, clean;

  always #2 clk_i = ~clk_i;

  bfh_sequencer DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .shutdown_i(sd),
    .supply_lockout_i(lock), .pwm_hs_req_i(pwm), .cycle_start_i(cs), .hs_ocp_cmp_i(hs_cmp),
    .ls_ocp_cmp_i(ls_cmp), .output_undervoltage_fault_i(uv), .bandgap_ref_i(bg),
    .ext_ss_ref_i(ext), .hs_gate_o(hs_g), .ls_gate_o(ls_g), .ext_ss_discharge_o(dis),
    .ea_ref_o(ref_o), .hiccup_o(hic), .soft_start_o(ss));
  bfh_power_stage PS (.clk_i(clk_i), .hs_gate_i(hs_g), .ls_gate_i(ls_g), .run_i(run),
    .ls_over_i(ls_over), .hs_at_i(hs_at), .cycle_start_o(cs), .pwm_hs_req_o(pwm),
    .hs_ocp_cmp_o(hs_cmp), .ls_ocp_cmp_o(ls_cmp));

  task automatic ticks(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task automatic final_report();
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [REF_W-1:0] got, input logic [REF_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reset_dut();
    rst_n_i <= 1'b0;
    ticks(16);
    rst_n_i <= 1'b1;
    ticks(4);
  endtask
  // Waits are bounded so a stuck gate or missed trip ends the run instead of hanging.
  task automatic wait_hic(input int lim);
    n = 0;
    while (hic !== 1'b1) begin
      if (n == lim) begin
        err_total++;
        $display("wrong value at %0t ns: got %h expected %h", $time, n, lim);
        final_report();
      end
      ticks(1);
      n++;
    end
  endtask
  task automatic wait_ls(input logic v);
    n = 0;
    while (ls_g !== v) begin
      if (n == 500) begin
        err_total++;
        $display("wrong value at %0t ns: got %h expected %h", $time, n, 500);
        final_report();
      end
      ticks(1);
      n++;
    end
  endtask
  task automatic ls_step(input logic over);
    ls_over <= over;
    wait_ls(1'b0);
    chk(n < 8, b[0]);
    b = over;
    wait_ls(1'b1);
    ticks(20);
    clean = over ? 0 : clean + 1;
    cnt = over ? cnt + 1 : (clean >= LS_CLEAR_CYCLES ? 0 : cnt);
    chk(hic, cnt >= LS_TRIP_EVENTS);
  endtask

  initial begin
    void'($urandom(95));
    reset_dut();
    for (int i = 0; i < 8; i++) begin
      a = $urandom_range(1023);
      b = $urandom_range(1023);
      bg <= a[REF_W-1:0];
      ext <= b[REF_W-1:0];
      ticks(4);
      chk(ref_o, REF_W'(a < b ? a : b));
    end
    reset_dut();
    bg <= 10'h1F4;
    ext <= 10'h064;
    run <= 1'b1;
    uv <= 1'b1;
    ticks(2000);
    chk(hic, 1'b0);
    uv <= 1'b0;
    ext <= 10'h3FF;
    ticks(5);
    uv <= 1'b1;
    ticks(UV_FILTER_CYC - 50);
    uv <= 1'b0;
    ticks(10);
    chk(hic, 1'b0);
    uv <= 1'b1;
    wait_hic(2000);
    chk(n >= UV_FILTER_CYC && n <= UV_FILTER_CYC + 8, 1'b1);
    uv <= 1'b0;
    ticks(8);
    chk({hs_g, ls_g}, 2'b00);
    chk(ss, 1'b0);
    chk(ref_o, REF_ZERO);
    chk(dis, 1'b0);
    for (int k = 0; k < 2; k++) begin
      sd <= (k == 0);
      lock <= (k == 1);
      ticks(6);
      chk(dis, 1'b1);
      chk({hs_g, ls_g}, 2'b00);
    end
    sd <= 1'b0;
    lock <= 1'b0;
    ticks(6);
    chk(dis, 1'b0);
    reset_dut();
    ext <= 10'h064;
    hs_at <= 10;
    ticks(1000);
    chk(hic, 1'b0);
    hs_at <= 70;
    wait_hic(400);
    ticks(2);
    chk({hs_g, ls_g}, 2'b00);
    hs_at <= 0;
    reset_dut();
    cnt = 0;
    clean = 0;
    b = 1;
    for (int i = 0; i < 61; i++) ls_step(i < 14 || i >= 46);
    final_report();
  end
endmodule
